/* File: logic/channel_input_filter.sv */
`timescale 1ns/1ps

// Accepts a new input level only after it has been stable for the delay.
module channel_input_filter
  import input_event_diagnostics_pkg::*;
#(
  parameter int CNT_W = DELAY_CNT_W
) (
  // Clock and reset.
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  // Raw input and delay.
  input  wire logic             i_raw,
  input  wire logic [CNT_W-1:0] i_delay_cycles,
  // Filtered level.
  output logic                  o_level
);

  if (CNT_W < 2) begin : g_check
    $error("channel_input_filter: counter too narrow");
  end

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             level;
  logic             next_level;

  // Both transition directions use the same delay.
  always_comb begin
    next_count = '0;
    next_level = level;
    if (i_raw != level) begin
      if (count + 1'b1 >= i_delay_cycles) begin
        next_level = i_raw;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      count <= '0;
      level <= 1'b0;
    end else begin
      count <= next_count;
      level <= next_level;
    end
  end

  assign o_level = level;

endmodule // channel_input_filter

/* File: logic/input_event_diagnostics.sv */
// How it works
// - Loss of load supply or a wire break on an enabled channel raises a diagnostic interrupt.
// - Each channel raises a hardware interrupt on rising, falling or both edges as selected.
// - Every diagnostic event posts one alarm, and the error lamp flashes while a fault stays.
// - A missing load supply alarm carries code 17.
// - An open input circuit alarm carries code 6.
// - An edge that arrives while a hardware interrupt is unacknowledged is dropped, code 22.
// - The lost-interrupt condition stays latched until a new parameter assignment.
// - Each channel's delay is 0.05, 0.1, 0.4, 1.6, 3.2, 12.8 or 20 ms for both directions.
// - In isochronous mode the shortest setting filters for at least 80 us in total.
// - With value status on, one validity bit per channel reads zero for an invalid reading.
// - Supply loss is judged per channel, so every enabled channel posts its own alarm.
`timescale 1ns/1ps

module input_event_diagnostics
  import input_event_diagnostics_pkg::*;
#(
  parameter int CHANNELS        = 16,
  parameter int DELAY_0_CYCLES  = DELAY_0_US * CLOCK_MHZ,
  parameter int DELAY_1_CYCLES  = DELAY_1_US * CLOCK_MHZ,
  parameter int DELAY_2_CYCLES  = DELAY_2_US * CLOCK_MHZ,
  parameter int DELAY_3_CYCLES  = DELAY_3_US * CLOCK_MHZ,
  parameter int DELAY_4_CYCLES  = DELAY_4_US * CLOCK_MHZ,
  parameter int DELAY_5_CYCLES  = DELAY_5_US * CLOCK_MHZ,
  parameter int DELAY_6_CYCLES  = DELAY_6_US * CLOCK_MHZ,
  parameter int ISO_MIN_CYCLES  = FILTER_PROC_MIN_US * CLOCK_MHZ,
  parameter int BLINK_CYCLES    = BLINK_HALF_MS * 1000 * CLOCK_MHZ
) (
  // Clock and reset.
  input  wire logic                i_clock,
  input  wire logic                i_nrst,
  // Wishbone slave.
  input  wire logic                i_wb_cyc,
  input  wire logic                i_wb_stb,
  input  wire logic                i_wb_we,
  input  wire logic [7:0]          i_wb_adr,
  input  wire logic [3:0]          i_wb_sel,
  input  wire logic [31:0]         i_wb_dat,
  output logic                     o_wb_ack,
  output logic [31:0]              o_wb_dat,
  // Field side.
  input  wire logic [CHANNELS-1:0] i_channel_in,
  input  wire logic [CHANNELS-1:0] i_wire_break,
  input  wire logic                i_supply_ok,
  // Indicators.
  output logic                     o_irq,
  output logic                     o_error_led
);

  if (CHANNELS < 1 || CHANNELS > 16 || DELAY_6_CYCLES >= (1 << DELAY_CNT_W)
      || BLINK_CYCLES < 2 || BLINK_CYCLES >= (1 << 24)) begin : g_check
    $error("input_event_diagnostics: unsupported parameter values");
  end

  localparam int CW = DELAY_CNT_W;

  // Parameter and control registers.
  logic [31:0]         delay_lo, next_delay_lo;
  logic [31:0]         delay_hi, next_delay_hi;
  logic [31:0]         edge_sel, next_edge_sel;
  logic [31:0]         diag_en, next_diag_en;
  logic                value_status, next_value_status;
  logic                iso_mode, next_iso_mode;
  logic [2:0]          int_status, next_int_status;
  logic [2:0]          int_mask, next_int_mask;
  // Event state.
  logic                hw_pending, next_hw_pending;
  logic                hw_rising, next_hw_rising;
  logic [3:0]          hw_channel, next_hw_channel;
  logic                lost_latched, next_lost_latched;
  logic                lost_pend, next_lost_pend;
  logic [CHANNELS-1:0] supply_pend, next_supply_pend;
  logic [CHANNELS-1:0] wire_pend, next_wire_pend;
  logic [CHANNELS-1:0] supply_seen, next_supply_seen;
  logic [CHANNELS-1:0] wire_seen, next_wire_seen;
  logic                alarm_valid, next_alarm_valid;
  logic [7:0]          alarm_code, next_alarm_code;
  logic [3:0]          alarm_chan, next_alarm_chan;
  logic [CHANNELS-1:0] filt_prev;
  // Bus and indicator outputs.
  logic                ack, next_ack;
  logic [31:0]         rdata, next_rdata;
  logic                irq, next_irq;
  logic [23:0]         blink_cnt, next_blink_cnt;
  logic                blink, next_blink;
  logic                led, next_led;

  logic [CHANNELS-1:0] filt;
  logic [CHANNELS-1:0] rise_ev;
  logic [CHANNELS-1:0] fall_ev;
  logic [CHANNELS-1:0] supply_fault;
  logic [CHANNELS-1:0] wire_fault;
  logic [CHANNELS-1:0] valid_bits;

  // Per-channel filter, edge and fault terms.
  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    logic [2:0]    sel;
    logic [CW-1:0] cycles;
    assign sel = (c < 8) ? delay_lo[(c % 8) * 4 +: 3] : delay_hi[(c % 8) * 4 +: 3];
    always_comb begin
      case (sel)
        3'h0:    cycles = iso_mode ? CW'(ISO_MIN_CYCLES) : CW'(DELAY_0_CYCLES);
        3'h1:    cycles = CW'(DELAY_1_CYCLES);
        3'h2:    cycles = CW'(DELAY_2_CYCLES);
        3'h3:    cycles = CW'(DELAY_3_CYCLES);
        3'h4:    cycles = CW'(DELAY_4_CYCLES);
        3'h5:    cycles = CW'(DELAY_5_CYCLES);
        default: cycles = CW'(DELAY_6_CYCLES);
      endcase
    end
    channel_input_filter #(.CNT_W(CW)) u_filter (
      .i_clock        (i_clock),
      .i_nrst         (i_nrst),
      .i_raw          (i_channel_in[c]),
      .i_delay_cycles (cycles),
      .o_level        (filt[c])
    );
    // Edges come from the filtered level, never the raw pin.
    assign rise_ev[c]      = filt[c] & ~filt_prev[c] & edge_sel[c];
    assign fall_ev[c]      = ~filt[c] & filt_prev[c] & edge_sel[16 + c];
    assign supply_fault[c] = ~i_supply_ok & diag_en[c];
    assign wire_fault[c]   = i_wire_break[c] & diag_en[16 + c];
    assign valid_bits[c]   = value_status & i_supply_ok & ~i_wire_break[c];
  end

  logic                 bus_req;
  logic                 wr;
  logic [31:0]          wmask;
  logic                 commit;
  logic                 any_edge;
  logic [3:0]           edge_chan;
  logic                 edge_rising;
  alarm_kind_t          pick;
  logic [3:0]           pick_chan;

  assign bus_req = i_wb_cyc & i_wb_stb & ~ack;
  assign wr      = i_wb_cyc & i_wb_stb & i_wb_we & ack;
  assign wmask   = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  assign commit  = wr & (i_wb_adr == REG_CONTROL) & i_wb_sel[0] & i_wb_dat[CTRL_COMMIT_BIT];

  // Lowest channel wins among simultaneous edges; the rest count as lost.
  always_comb begin
    any_edge    = 1'b0;
    edge_chan   = 4'h0;
    edge_rising = 1'b0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (rise_ev[i] | fall_ev[i]) begin
        any_edge    = 1'b1;
        edge_chan   = 4'(i);
        edge_rising = rise_ev[i];
      end
    end
  end

  // Alarm selection: lost interrupt first, then supply, then wire break.
  always_comb begin
    pick      = ALARM_NONE;
    pick_chan = 4'h0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (wire_pend[i]) begin
        pick      = ALARM_WIRE;
        pick_chan = 4'(i);
      end
    end
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (supply_pend[i]) begin
        pick      = ALARM_SUPPLY;
        pick_chan = 4'(i);
      end
    end
    if (lost_pend) begin
      pick      = ALARM_LOST;
      pick_chan = hw_channel;
    end
  end

  // Event and alarm state.
  always_comb begin
    logic ack_hw;
    logic ack_alarm;
    logic hw_edge_lost;
    ack_hw       = wr & (i_wb_adr == REG_HW_INT) & i_wb_sel[0] & i_wb_dat[HW_PENDING_BIT];
    ack_alarm    = wr & (i_wb_adr == REG_ALARM) & i_wb_sel[3] & i_wb_dat[ALARM_VALID_BIT];
    hw_edge_lost = 1'b0;

    next_hw_pending   = hw_pending & ~ack_hw;
    next_hw_rising    = hw_rising;
    next_hw_channel   = hw_channel;
    next_lost_latched = lost_latched & ~commit;
    next_lost_pend    = lost_pend;
    next_supply_seen  = supply_fault;
    next_wire_seen    = wire_fault;
    // A fault onset sets its alarm; a fault that ends before posting is still reported.
    next_supply_pend  = supply_pend | (supply_fault & ~supply_seen);
    next_wire_pend    = wire_pend | (wire_fault & ~wire_seen);
    next_alarm_valid  = alarm_valid & ~ack_alarm;
    next_alarm_code   = alarm_code;
    next_alarm_chan   = alarm_chan;

    if (any_edge) begin
      if (hw_pending) begin
        hw_edge_lost = 1'b1;
      end else begin
        next_hw_pending = 1'b1;
        next_hw_rising  = edge_rising;
        next_hw_channel = edge_chan;
      end
      if ((rise_ev | fall_ev) != (CHANNELS'(1) << edge_chan)) begin
        hw_edge_lost = 1'b1;
      end
    end
    if (hw_edge_lost) begin
      next_lost_latched = 1'b1;
      next_lost_pend    = 1'b1;
    end

    // The mailbox holds one alarm; the next one posts once software frees it.
    if (!next_alarm_valid && pick != ALARM_NONE) begin
      next_alarm_valid = 1'b1;
      next_alarm_chan  = pick_chan;
      case (pick)
        ALARM_LOST: begin
          next_alarm_code = CODE_HW_INT_LOST;
          next_lost_pend  = hw_edge_lost;
        end
        ALARM_SUPPLY: begin
          next_alarm_code = CODE_SUPPLY_MISSING;
          next_supply_pend[pick_chan] = supply_fault[pick_chan] & ~supply_seen[pick_chan];
        end
        default: begin
          next_alarm_code = CODE_WIRE_BREAK;
          next_wire_pend[pick_chan] = wire_fault[pick_chan] & ~wire_seen[pick_chan];
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      hw_pending   <= 1'b0;
      hw_rising    <= 1'b0;
      hw_channel   <= 4'h0;
      lost_latched <= 1'b0;
      lost_pend    <= 1'b0;
      supply_pend  <= '0;
      wire_pend    <= '0;
      supply_seen  <= '0;
      wire_seen    <= '0;
      alarm_valid  <= 1'b0;
      alarm_code   <= 8'h00;
      alarm_chan   <= 4'h0;
      filt_prev    <= '0;
    end else begin
      hw_pending   <= next_hw_pending;
      hw_rising    <= next_hw_rising;
      hw_channel   <= next_hw_channel;
      lost_latched <= next_lost_latched;
      lost_pend    <= next_lost_pend;
      supply_pend  <= next_supply_pend;
      wire_pend    <= next_wire_pend;
      supply_seen  <= next_supply_seen;
      wire_seen    <= next_wire_seen;
      alarm_valid  <= next_alarm_valid;
      alarm_code   <= next_alarm_code;
      alarm_chan   <= next_alarm_chan;
      filt_prev    <= filt;
    end
  end

  // Registers, interrupt status and bus answer.
  always_comb begin
    logic [2:0] events;
    logic [2:0] clear;
    events = '0;
    events[IRQ_HW_BIT]    = next_hw_pending & ~hw_pending;
    events[IRQ_ALARM_BIT] = next_alarm_valid & ~alarm_valid;
    events[IRQ_LOST_BIT]  = next_lost_latched & ~lost_latched;
    clear = '0;

    next_delay_lo     = delay_lo;
    next_delay_hi     = delay_hi;
    next_edge_sel     = edge_sel;
    next_diag_en      = diag_en;
    next_value_status = value_status;
    next_iso_mode     = iso_mode;
    next_int_mask     = int_mask;
    next_ack          = bus_req;
    next_rdata        = 32'h0000_0000;

    if (wr) begin
      case (i_wb_adr)
        REG_CONTROL: begin
          if (i_wb_sel[0]) begin
            next_value_status = i_wb_dat[CTRL_VALUE_STATUS_BIT];
            next_iso_mode     = i_wb_dat[CTRL_ISOCHRONOUS_BIT];
          end
        end
        REG_DELAY_LO:   next_delay_lo = (delay_lo & ~wmask) | (i_wb_dat & wmask);
        REG_DELAY_HI:   next_delay_hi = (delay_hi & ~wmask) | (i_wb_dat & wmask);
        REG_EDGE_SEL:   next_edge_sel = (edge_sel & ~wmask) | (i_wb_dat & wmask);
        REG_DIAG_EN:    next_diag_en  = (diag_en & ~wmask) | (i_wb_dat & wmask);
        REG_INT_STATUS: clear = i_wb_dat[2:0] & {3{i_wb_sel[0]}};
        REG_INT_MASK:   next_int_mask = i_wb_sel[0] ? i_wb_dat[2:0] : int_mask;
        default: ;
      endcase
    end else if (bus_req && !i_wb_we) begin
      case (i_wb_adr)
        REG_CONTROL: begin
          next_rdata[CTRL_VALUE_STATUS_BIT] = value_status;
          next_rdata[CTRL_ISOCHRONOUS_BIT]  = iso_mode;
        end
        REG_VALUES: begin
          next_rdata[CHANNELS-1:0]    = filt;
          next_rdata[16 +: CHANNELS]  = valid_bits;
        end
        REG_DELAY_LO:   next_rdata = delay_lo;
        REG_DELAY_HI:   next_rdata = delay_hi;
        REG_EDGE_SEL:   next_rdata = edge_sel;
        REG_DIAG_EN:    next_rdata = diag_en;
        REG_HW_INT: begin
          next_rdata[HW_PENDING_BIT]          = hw_pending;
          next_rdata[HW_RISING_BIT]           = hw_rising;
          next_rdata[HW_CHANNEL_LSB +: 4]     = hw_channel;
        end
        REG_ALARM: begin
          next_rdata[7:0]                     = alarm_code;
          next_rdata[ALARM_CHAN_LSB +: 4]     = alarm_chan;
          next_rdata[ALARM_VALID_BIT]         = alarm_valid;
        end
        REG_INT_STATUS: next_rdata[2:0] = int_status;
        REG_INT_MASK:   next_rdata[2:0] = int_mask;
        REG_DIAG_STATE: begin
          next_rdata[CHANNELS-1:0] = supply_fault | wire_fault;
          next_rdata[16]           = lost_latched;
          next_rdata[17]           = i_supply_ok;
        end
        default: ;
      endcase
    end

    // A new event in the clearing cycle keeps its bit set.
    next_int_status = (int_status & ~clear) | events;
    next_irq        = |(next_int_status & next_int_mask);

    // Lamp flashes while any fault or the lost latch is present.
    next_blink_cnt = blink_cnt + 24'h00_0001;
    next_blink     = blink;
    if (blink_cnt >= 24'(BLINK_CYCLES - 1)) begin
      next_blink_cnt = 24'h00_0000;
      next_blink     = ~blink;
    end
    next_led = (|(supply_fault | wire_fault) | lost_latched) & next_blink;
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      delay_lo     <= DELAY_LO_RESET;
      delay_hi     <= DELAY_HI_RESET;
      edge_sel     <= 32'h0000_0000;
      diag_en      <= 32'h0000_0000;
      value_status <= 1'b0;
      iso_mode     <= 1'b0;
      int_status   <= 3'h0;
      int_mask     <= 3'h0;
      ack          <= 1'b0;
      rdata        <= 32'h0000_0000;
      irq          <= 1'b0;
      blink_cnt    <= 24'h00_0000;
      blink        <= 1'b0;
      led          <= 1'b0;
    end else begin
      delay_lo     <= next_delay_lo;
      delay_hi     <= next_delay_hi;
      edge_sel     <= next_edge_sel;
      diag_en      <= next_diag_en;
      value_status <= next_value_status;
      iso_mode     <= next_iso_mode;
      int_status   <= next_int_status;
      int_mask     <= next_int_mask;
      ack          <= next_ack;
      rdata        <= next_rdata;
      irq          <= next_irq;
      blink_cnt    <= next_blink_cnt;
      blink        <= next_blink;
      led          <= next_led;
    end
  end

  assign o_wb_ack    = ack;
  assign o_wb_dat    = rdata;
  assign o_irq       = irq;
  assign o_error_led = led;

endmodule // input_event_diagnostics

/* File: logic/input_event_diagnostics_pkg.sv */
package input_event_diagnostics_pkg;

  // Word-aligned Wishbone byte offsets.
  localparam logic [7:0] REG_CONTROL    = 8'h00;
  localparam logic [7:0] REG_VALUES     = 8'h04;
  localparam logic [7:0] REG_DELAY_LO   = 8'h08;
  localparam logic [7:0] REG_DELAY_HI   = 8'h0C;
  localparam logic [7:0] REG_EDGE_SEL   = 8'h10;
  localparam logic [7:0] REG_DIAG_EN    = 8'h14;
  localparam logic [7:0] REG_HW_INT     = 8'h18;
  localparam logic [7:0] REG_ALARM      = 8'h1C;
  localparam logic [7:0] REG_INT_STATUS = 8'h20;
  localparam logic [7:0] REG_INT_MASK   = 8'h24;
  localparam logic [7:0] REG_DIAG_STATE = 8'h28;

  // Control register fields.
  localparam int CTRL_VALUE_STATUS_BIT = 0;
  localparam int CTRL_ISOCHRONOUS_BIT  = 1;
  localparam int CTRL_COMMIT_BIT       = 2;

  // Hardware interrupt and alarm mailbox fields.
  localparam int HW_PENDING_BIT  = 0;
  localparam int HW_RISING_BIT   = 1;
  localparam int HW_CHANNEL_LSB  = 4;
  localparam int ALARM_CHAN_LSB  = 8;
  localparam int ALARM_VALID_BIT = 31;

  // Interrupt status bits.
  localparam int IRQ_HW_BIT    = 0;
  localparam int IRQ_ALARM_BIT = 1;
  localparam int IRQ_LOST_BIT  = 2;

  // Diagnostic error codes (decimal).
  localparam logic [7:0] CODE_SUPPLY_MISSING = 8'd17;
  localparam logic [7:0] CODE_WIRE_BREAK     = 8'd6;
  localparam logic [7:0] CODE_HW_INT_LOST    = 8'd22;

  // Delay selector encodings; the preset is 3.2 ms.
  localparam logic [2:0] DELAY_SEL_RESET = 3'h4;
  localparam logic [31:0] DELAY_LO_RESET = 32'h4444_4444;
  localparam logic [31:0] DELAY_HI_RESET = 32'h4444_4444;

  // Filter delays in microseconds and the clock rate.
  localparam int CLOCK_MHZ          = 20;
  localparam int DELAY_0_US         = 50;
  localparam int DELAY_1_US         = 100;
  localparam int DELAY_2_US         = 400;
  localparam int DELAY_3_US         = 1600;
  localparam int DELAY_4_US         = 3200;
  localparam int DELAY_5_US         = 12800;
  localparam int DELAY_6_US         = 20000;
  localparam int FILTER_PROC_MIN_US = 80;
  localparam int BUS_CYCLE_MIN_US   = 250;
  localparam int BLINK_HALF_MS      = 250;
  localparam int DELAY_CNT_W        = 23;

  typedef enum logic [1:0] {
    ALARM_NONE   = 2'b00,
    ALARM_LOST   = 2'b01,
    ALARM_SUPPLY = 2'b10,
    ALARM_WIRE   = 2'b11
  } alarm_kind_t;

endpackage

/* File: test/controller_model.sv */
`timescale 1ns/1ps

// Backplane controller: one classic Wishbone cycle at a time.
module controller_model (
  // Clock.
  input  wire logic        i_clock,
  // Wishbone master.
  output logic             o_cyc,
  output logic             o_stb,
  output logic             o_we,
  output logic [7:0]       o_adr,
  output logic [3:0]       o_sel,
  output logic [31:0]      o_dat,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_dat
);
  initial begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we  = 1'b0;
    o_adr = 8'hFF;
    o_sel = 4'h0;
    o_dat = 32'h0;
  end
  // The caller paces exchanges; cycles never come faster than it asks.
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat, output logic [31:0] rdat);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we  <= we;
    o_adr <= adr;
    o_sel <= sel;
    o_dat <= dat;
    do @(posedge i_clock); while (i_ack !== 1'b1);
    rdat = i_dat;
    // Released address and data lines show the inverse so nothing relies on stale values.
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    o_adr <= ~adr;
    o_dat <= ~dat;
    @(posedge i_clock);
  endtask
endmodule // controller_model

/* File: test/input_event_diagnostics_chk.sv */
`timescale 1ns/1ps

module input_event_diagnostics_chk
  import input_event_diagnostics_pkg::*;
#(
  parameter int BLINK_CYCLES = 16
) (
  input wire logic        i_clock,
  input wire logic        i_nrst,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  input wire logic        i_supply_ok,
  input wire logic        o_irq,
  input wire logic        o_error_led
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  logic req;
  int   led_run;
  int   next_led_run;
  assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  // A lamp stuck on is not flashing, so the lit span is capped.
  always_comb begin
    next_led_run = o_error_led ? led_run + 1 : 0;
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) led_run <= 0;
    else led_run <= next_led_run;
  end
  AST_ACK_ONE: assert property (req |=> o_wb_ack)
    else $error("request not answered in one cycle");
  AST_ACK_DROP: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data outside ack cycle");
  AST_UNMAPPED: assert property (req && !i_wb_we && i_wb_adr > REG_DIAG_STATE
    |=> o_wb_ack && o_wb_dat == 32'h0) else $error("unmapped read not zero");
  AST_VALIDITY: assert property ((!i_supply_ok)[*4] ##0 (req && !i_wb_we
    && i_wb_adr == REG_VALUES) |=> o_wb_dat[31:16] == 16'h0) else $error("validity set");
  AST_MASK_OFF: assert property (req && i_wb_we && i_wb_adr == REG_INT_MASK
    && i_wb_sel[0] && i_wb_dat[2:0] == 3'h0 |-> ##3 !o_irq) else $error("irq while masked");
  AST_LED_BLINK: assert property (led_run <= BLINK_CYCLES)
    else $error("error lamp lit too long");
  cover property ($rose(o_irq));
  cover property ($rose(o_error_led));
  cover property (o_wb_ack && o_wb_dat[31]);
endmodule // input_event_diagnostics_chk

bind input_event_diagnostics input_event_diagnostics_chk #(.BLINK_CYCLES(BLINK_CYCLES))
  u_input_event_diagnostics_chk (.i_clock(i_clock), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
  .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_supply_ok(i_supply_ok),
  .o_irq(o_irq), .o_error_led(o_error_led));

/* File: test/test_input_event_diagnostics.sv */
`timescale 1ns/1ps

module test_input_event_diagnostics;
  import input_event_diagnostics_pkg::*;
  logic        clock, nrst, cyc, stb, we, ack, sup, irq, led;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, v;
  logic [15:0] ch_in, brk;
  int          miscompares, n_checks;

  input_event_diagnostics #(.DELAY_0_CYCLES(4), .DELAY_4_CYCLES(12), .ISO_MIN_CYCLES(16),
    .BLINK_CYCLES(16)) u_input_event_diagnostics (.i_clock(clock),
    .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat), .i_channel_in(ch_in),
    .i_wire_break(brk), .i_supply_ok(sup), .o_irq(irq), .o_error_led(led));
  controller_model u_controller_model (.i_clock(clock), .o_cyc(cyc), .o_stb(stb), .o_we(we),
    .o_adr(adr), .o_sel(sel), .o_dat(wdat), .i_ack(ack), .i_dat(rdat));

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_controller_model.xfer(1'b1, a, 4'hF, d, x);
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk(input string what, input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    u_controller_model.xfer(1'b0, a, 4'hF, 32'h0, v);
    cmp(what, e & m, v & m);
  endtask
  task automatic step(input logic [15:0] lvl, input int n);
    ch_in <= lvl;
    repeat (n) @(posedge clock);
  endtask
  task automatic t_reset();
    chk("delay_lo", REG_DELAY_LO, DELAY_LO_RESET, 32'hFFFFFFFF);
    chk("delay_hi", REG_DELAY_HI, DELAY_HI_RESET, 32'hFFFFFFFF);
    // Only byte 1 is enabled, so the other three bytes keep their preset.
    u_controller_model.xfer(1'b1, REG_DELAY_HI, 4'h2, 32'h0000_7700, v);
    chk("delay_hi_sel", REG_DELAY_HI, 32'h4444_7744, 32'hFFFFFFFF);
    chk("edge_sel", REG_EDGE_SEL, 32'h0, 32'hFFFFFFFF);
    wr(8'h30, 32'hFFFFFFFF);
    chk("unmapped", 8'h30, 32'h0, 32'hFFFFFFFF);
  endtask
  // Channel 0 both edges, channel 1 falling only, shortest delay.
  task automatic t_edges();
    wr(REG_INT_MASK, 32'h7);
    wr(REG_DELAY_LO, 32'h0);
    wr(REG_EDGE_SEL, 32'h0003_0001);
    step(16'h0003, 2);
    step(16'h0002, 20);
    chk("glitch", REG_HW_INT, 32'h0, 32'h1);
    step(16'h0003, 20);
    chk("rise", REG_HW_INT, 32'h03, 32'hFF);
    cmp("irq", 32'h1, {31'h0, irq});
    wr(REG_HW_INT, 32'h1);
    step(16'h0002, 20);
    chk("fall", REG_HW_INT, 32'h01, 32'hFF);
    wr(REG_HW_INT, 32'h1);
    step(16'h0000, 20);
    chk("fall1", REG_HW_INT, 32'h11, 32'hFF);
  endtask
  task automatic t_lost();
    step(16'h0001, 20);
    chk("held", REG_HW_INT, 32'h11, 32'hFF);
    chk("lost", REG_ALARM, 32'h8000_0016, 32'h8000_00FF);
    wr(REG_ALARM, 32'h8000_0000);
    wr(REG_HW_INT, 32'h1);
    chk("latch", REG_DIAG_STATE, 32'h1_0000, 32'h1_0000);
    wr(REG_CONTROL, 32'h4);
    chk("commit", REG_DIAG_STATE, 32'h0, 32'h1_0000);
    wr(REG_INT_STATUS, 32'h7);
  endtask
  // A pulse longer than the plain filter but under the isochronous minimum.
  task automatic t_iso();
    wr(REG_CONTROL, 32'h2);
    step(16'h0000, 10);
    step(16'h0001, 20);
    chk("iso", REG_HW_INT, 32'h0, 32'h1);
    wr(REG_CONTROL, 32'h0);
  endtask
  task automatic t_diag();
    int t;
    wr(REG_CONTROL, 32'h1);
    wr(REG_DIAG_EN, 32'h0020_000C);
    sup <= 1'b0;
    repeat (6) @(posedge clock);
    chk("supply2", REG_ALARM, 32'h8000_0211, 32'h8000_0FFF);
    wr(REG_ALARM, 32'h8000_0000);
    chk("supply3", REG_ALARM, 32'h8000_0311, 32'h8000_0FFF);
    wr(REG_ALARM, 32'h8000_0000);
    chk("valid", REG_VALUES, 32'h0, 32'h000C_0000);
    cmp("irq", 32'h1, {31'h0, irq});
    t = 0;
    repeat (40) begin
      @(posedge clock);
      if (led !== v[0]) t++;
      v[0] = led;
    end
    cmp("blink", 32'h1, {31'h0, t >= 2});
    sup <= 1'b1;
    brk <= 16'h0020;
    repeat (6) @(posedge clock);
    chk("wire", REG_ALARM, 32'h8000_0506, 32'h8000_0FFF);
    wr(REG_ALARM, 32'h8000_0000);
    chk("valid5", REG_VALUES, 32'h0, 32'h0020_0000);
    wr(REG_INT_MASK, 32'h0);
    repeat (2) @(posedge clock);
    cmp("masked", 32'h0, {31'h0, irq});
    brk <= 16'h0000;
  endtask
  task automatic end_sim();
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    end_sim();
  end
  initial begin
    miscompares = 0;
    n_checks = 0;
    nrst = 1'b0;
    ch_in = 16'h0002;
    brk = 16'h0000;
    sup = 1'b1;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_reset();
    t_edges();
    t_lost();
    t_iso();
    t_diag();
    end_sim();
  end
endmodule // test_input_event_diagnostics
